// ---- src/bulk_in_params.svh ----
// constants for the bulk-in frame encapsulator
`ifndef BULK_IN_PARAMS_SVH
`define BULK_IN_PARAMS_SVH
`define DATA_DEPTH 2048
`define DATA_AW 11
`define CMD_DEPTH 32
`define CMD_AW 5
`define MPS_SS 11'h400
`define MPS_HS 11'h200
`define MPS_FS 11'h040
`define SPEED_FS 2'h0
`define SPEED_HS 2'h1
`define SPEED_SS 2'h2
`define DELAY_DEFAULT_NS 34000
`define CLK_PERIOD_NS 50
`define DELAY_DEFAULT_CYC 16'h02a8
`define RX_CMD_WORDS 2'h3
`endif

// ---- src/bulk_in_pkg.sv ----
// types for the bulk-in frame encapsulator
package bulk_in_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_CMDA = 6'h02,
    ST_CMDBC = 6'h04,
    ST_DATA = 6'h08,
    ST_CLOSE = 6'h10,
    ST_ZLP = 6'h20
  } mover_state_t;
  typedef struct packed {
    logic [10:0] len;
  } pkt_cmd_t;
  typedef struct packed {
    logic ack;
    logic nack;
  } in_result_t;
endpackage

// ---- src/usb_bulk_in_frame_encapsulator.sv ----
// bulk-in transmitter: packs receive frames into bulk in packets
`include "bulk_in_params.svh"

module usb_bulk_in_frame_encapsulator #(
  parameter logic [15:0] DELAY_CYC = `DELAY_DEFAULT_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // configuration
  input wire logic multi_frame_packing_i,
  input wire logic empty_in_response_bit_i,
  input wire logic burst_limit_enable_i,
  input wire logic [7:0] burst_limit_i,
  input wire logic [15:0] in_delay_register_i,
  input wire logic [3:0] ss_max_burst_field_i,
  input wire logic [1:0] speed_i,
  // receive FIFO of the fifo controller
  input wire logic [13:0] rx_fifo_size_i,
  input wire logic [31:0] rx_data_i,
  output logic rx_pop_o,
  output logic rewind_o,
  output logic ack_notify_o,
  // usb device controller
  input wire logic token_i,
  input wire logic tx_word_i,
  input wire logic tx_done_i,
  input wire bulk_in_pkg::in_result_t result_i,
  output logic [10:0] pkt_len_o,
  output logic [5:0] pkt_count_o,
  output logic [31:0] tx_data_o,
  output logic send_zlp_o,
  output logic send_nak_o,
  output logic send_nrdy_o,
  output logic release_o,
  output logic cmd_full_o
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [10:0] mps(input logic [1:0] sp);
    unique case (sp)
      `SPEED_SS: mps = `MPS_SS;
      `SPEED_HS: mps = `MPS_HS;
      default: mps = `MPS_FS;
    endcase
  endfunction
  function automatic logic [13:0] dwords(input logic [13:0] bytes);
    dwords = (bytes + 14'h0003) >> 2;
  endfunction

  logic [31:0] data_mem [0:`DATA_DEPTH-1];
  bulk_in_pkg::pkt_cmd_t cmd_mem [0:`CMD_DEPTH-1];
  logic [`DATA_AW:0] wr_ptr, rd_ptr, free_ptr;
  logic [`CMD_AW:0] cmd_wr, cmd_rd, cmd_sent;
  logic [13:0] rem;
  logic [10:0] pkt_acc;
  logic [19:0] burst_cur;
  logic [15:0] timer;
  logic timer_run, timer_done;
  logic [1:0] cmd_cnt;
  bulk_in_pkg::mover_state_t state;
  logic [10:0] max_ps;
  logic [11:0] data_fill;
  logic [5:0] cmd_fill;
  logic [19:0] burst_max;
  logic [13:0] frame_len;
  logic [15:0] delay_lim;
  logic cmd_push, cmd_pop, pkt_full_word;
  logic [10:0] push_len;
  logic frame_end, pad_next;
  logic [1:0] size_s0, size_s1;
  logic [13:0] size_sync0, size_sync1;

  assign max_ps = mps(speed_i);
  // burst limit scaled by packet size
  assign burst_max = 20'(burst_limit_i) * 20'(max_ps);
  assign data_fill = 12'(wr_ptr - free_ptr);
  assign cmd_fill = 6'(cmd_wr - cmd_rd);
  // full flag since commands may fill first
  assign cmd_full_o = (cmd_fill == 6'(`CMD_DEPTH));
  // burst field is not used anywhere here and never sets the limit
  assign delay_lim = (in_delay_register_i == 16'h0000) ? 16'h0000 :
                     in_delay_register_i;
  assign frame_len = size_sync1;

  // size signal crosses from the fifo controller as a level
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      size_sync0 <= 14'h0000;
      size_sync1 <= 14'h0000;
    end else begin
      size_sync0 <= rx_fifo_size_i;
      size_sync1 <= size_sync0;
    end
  end
  assign size_s0 = 2'h0;
  assign size_s1 = 2'h0;

  // ----------------------------------------------------------------
  // frame mover
  // ----------------------------------------------------------------
  // last dword of frame; pad only when another frame waits
  assign frame_end = (state == bulk_in_pkg::ST_DATA) && (rem <= 14'h0004);
  // pad when another frame is available in multi mode
  assign pad_next = multi_frame_packing_i &&
                    (size_sync1 > dwords(rem) << 2);
  assign pkt_full_word = (state == bulk_in_pkg::ST_DATA) &&
                         (pkt_acc + 11'h004 >= max_ps);
  assign rx_pop_o = (state == bulk_in_pkg::ST_CMDA) ||
                    (state == bulk_in_pkg::ST_CMDBC) ||
                    (state == bulk_in_pkg::ST_DATA);

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= bulk_in_pkg::ST_IDLE;
      rem <= 14'h0000;
      cmd_cnt <= 2'h0;
      pkt_acc <= 11'h000;
      burst_cur <= 20'h00000;
      wr_ptr <= '0;
    end else begin
      unique case (state)
        bulk_in_pkg::ST_IDLE: begin
          // only start when free words exceed the payload dwords, the 3 command words not counted, and a command slot waits
          if (size_sync1 != 14'h0000 && !cmd_full_o &&
              12'(`DATA_DEPTH) - data_fill > 12'(dwords(size_sync1))) begin
            // limited burst stops before overflow, first unchecked
            if (burst_limit_enable_i && burst_cur != 20'h00000 &&
                burst_cur + 20'(size_sync1) > burst_max)
              state <= bulk_in_pkg::ST_CLOSE;
            else
              state <= bulk_in_pkg::ST_CMDA;
          end else if (pkt_acc != 11'h000 && !cmd_full_o && timer_done)
            state <= bulk_in_pkg::ST_CLOSE;
        end
        bulk_in_pkg::ST_CMDA: begin
          // frame length from first command word
          cmd_cnt <= `RX_CMD_WORDS - 2'h1;
          state <= bulk_in_pkg::ST_CMDBC;
          data_mem[wr_ptr[`DATA_AW-1:0]] <= rx_data_i;
          wr_ptr <= wr_ptr + 1'b1;
          pkt_acc <= pkt_acc + 11'h004;
          rem <= rx_data_i[13:0] + 14'h0008;
        end
        bulk_in_pkg::ST_CMDBC: begin
          data_mem[wr_ptr[`DATA_AW-1:0]] <= rx_data_i;
          wr_ptr <= wr_ptr + 1'b1;
          pkt_acc <= pkt_acc + 11'h004;
          rem <= rem - 14'h0004;
          cmd_cnt <= cmd_cnt - 2'h1;
          if (cmd_cnt == 2'h1)
            state <= bulk_in_pkg::ST_DATA;
        end
        bulk_in_pkg::ST_DATA: begin
          data_mem[wr_ptr[`DATA_AW-1:0]] <= rx_data_i;
          wr_ptr <= wr_ptr + 1'b1;
          rem <= (rem > 14'h0004) ? rem - 14'h0004 : 14'h0000;
          if (frame_end) begin
            burst_cur <= burst_cur + 20'(size_sync1);
            // pad counts in packet length; single mode no pad
            pkt_acc <= pkt_acc + (pad_next ? 11'h004 : 11'(rem));
            if (!multi_frame_packing_i)
              state <= bulk_in_pkg::ST_CLOSE;
            else
              state <= bulk_in_pkg::ST_IDLE;
          end else if (pkt_full_word) begin
            pkt_acc <= 11'h000;
          end else
            pkt_acc <= pkt_acc + 11'h004;
        end
        bulk_in_pkg::ST_CLOSE: begin
          pkt_acc <= 11'h000;
          burst_cur <= 20'h00000;
          // a full last packet also ends the transfer, so it needs a ZLP
          state <= ((pkt_acc == 11'h000 || pkt_acc == max_ps) &&
                    !cmd_full_o) ?
                   bulk_in_pkg::ST_ZLP : bulk_in_pkg::ST_IDLE;
        end
        bulk_in_pkg::ST_ZLP: state <= bulk_in_pkg::ST_IDLE;
        default: state <= bulk_in_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // command FIFO
  // ----------------------------------------------------------------
  // lengths written on packet completion, ZLP included
  always_comb begin
    cmd_push = 1'b0;
    push_len = 11'h000;
    if (pkt_full_word && !frame_end) begin
      cmd_push = 1'b1;
      push_len = max_ps;
    end else if (state == bulk_in_pkg::ST_CLOSE && pkt_acc != 11'h000) begin
      cmd_push = 1'b1;
      push_len = pkt_acc;
    end else if (state == bulk_in_pkg::ST_ZLP) begin
      cmd_push = 1'b1;
      push_len = 11'h000;
    end
  end
  assign cmd_pop = tx_done_i && result_i.ack && (cmd_fill != 6'h00);

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_wr <= '0;
    end else if (cmd_push && !cmd_full_o) begin
      cmd_mem[cmd_wr[`CMD_AW-1:0]] <= '{len: push_len};
      cmd_wr <= cmd_wr + 1'b1;
    end
  end

  // pop only on ACK, keep unacked entries for retry
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_rd <= '0;
      free_ptr <= '0;
    end else if (cmd_pop) begin
      cmd_rd <= cmd_rd + 1'b1;
      // zero length entries free no data space
      free_ptr <= free_ptr + (`DATA_AW+1)'(dwords(14'(cmd_mem[cmd_rd[`CMD_AW-1:0]].len)));
    end
  end

  // head length and depth presented to the controller
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pkt_len_o <= 11'h000;
      pkt_count_o <= 6'h00;
    end else begin
      pkt_len_o <= cmd_mem[cmd_rd[`CMD_AW-1:0]].len;
      pkt_count_o <= cmd_fill;
    end
  end

  // ----------------------------------------------------------------
  // transmit read side and retry
  // ----------------------------------------------------------------
  // no ACK rewinds read pointer to the oldest unacked packet
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_ptr <= '0;
      tx_data_o <= 32'h00000000;
      rewind_o <= 1'b0;
      ack_notify_o <= 1'b0;
      release_o <= 1'b0;
    end else begin
      rewind_o <= tx_done_i && result_i.nack;
      ack_notify_o <= tx_done_i && result_i.ack;
      // short packets are queued without the delay in single mode or on the burst limit, else once it ran out, so any
      // queued entry may go; clearing the timer on close cannot stall it
      release_o <= token_i && cmd_fill != 6'h00;
      if (tx_done_i && result_i.nack)
        rd_ptr <= free_ptr;
      else if (tx_word_i) begin
        tx_data_o <= data_mem[rd_ptr[`DATA_AW-1:0]];
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
  assign cmd_sent = cmd_rd;

  // ----------------------------------------------------------------
  // bulk-in delay timer
  // ----------------------------------------------------------------
  // timer runs while short data waits in multi mode
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer <= 16'h0000;
      timer_run <= 1'b0;
    end else if (!multi_frame_packing_i || delay_lim == 16'h0000) begin
      timer <= 16'h0000;
      timer_run <= 1'b0;
    end else if (cmd_push && push_len == max_ps) begin
      timer <= 16'h0000;
      timer_run <= 1'b1;
    end else if (state == bulk_in_pkg::ST_CLOSE) begin
      timer_run <= 1'b0;
      timer <= 16'h0000;
    end else if ((pkt_acc != 11'h000 || timer_run) && !timer_done) begin
      timer_run <= 1'b1;
      timer <= timer + 16'h0001;
    end
  end
  assign timer_done = !multi_frame_packing_i || delay_lim == 16'h0000 ||
                      (timer_run && timer >= delay_lim);

  // empty token answered per empty response bit, waiting token with NAK or NRDY by speed
  always_comb begin
    send_zlp_o = 1'b0;
    send_nak_o = 1'b0;
    send_nrdy_o = 1'b0;
    if (token_i && cmd_fill == 6'h00) begin
      if (empty_in_response_bit_i && size_sync1 == 14'h0000 &&
          pkt_acc == 11'h000)
        send_zlp_o = 1'b1;
      else if (speed_i == `SPEED_SS)
        send_nrdy_o = 1'b1;
      else
        send_nak_o = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_CMD_FULL: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    cmd_full_o |-> cmd_fill == 6'h20)
    else $error("command full flag wrong");
  AST_ACK_NOTIFY: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (tx_done_i && result_i.ack) |=> ack_notify_o)
    else $error("ack not notified");
  AST_REWIND: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (tx_done_i && result_i.nack) |=> rewind_o && rd_ptr == $past(free_ptr))
    else $error("rewind missing");
  AST_COUNT: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    1'b1 |=> pkt_count_o == $past(cmd_fill))
    else $error("packet count stale");
  AST_ZLP_EMPTY: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    send_zlp_o |-> empty_in_response_bit_i && cmd_fill == 6'h00)
    else $error("zlp without empty response");
  AST_NAK_SPEED: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    send_nak_o |-> speed_i != `SPEED_SS && !send_nrdy_o)
    else $error("nak at wrong speed");
  AST_ZLP_PUSH: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    state == bulk_in_pkg::ST_ZLP |-> cmd_push && push_len == 11'h000)
    else $error("zlp not queued");
  AST_POP_ACK: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    cmd_rd != $past(cmd_rd) |-> $past(tx_done_i && result_i.ack))
    else $error("pop without ack");
  AST_NO_DELAY_SEF: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    !multi_frame_packing_i |-> timer_done)
    else $error("delay active in single mode");
endmodule

// ---- verification/usb_dev_model.sv ----
// usb device controller model that serves bulk in tokens
module usb_dev_model (
  // clock
  input wire logic clock_i,
  // from the encapsulator
  input wire logic [10:0] len_i,
  input wire logic [31:0] data_i,
  input wire logic zlp_i,
  input wire logic nak_i,
  input wire logic nrdy_i,
  input wire logic rewind_i,
  input wire logic notify_i,
  // to the encapsulator
  output logic token_o,
  output logic word_o,
  output logic done_o,
  output bulk_in_pkg::in_result_t result_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic zlp_seen, nak_seen, nrdy_seen, rew_seen, ack_seen;
  logic [31:0] first_word;
  initial begin
    token_o = 1'b0;
    word_o = 1'b0;
    done_o = 1'b0;
    result_o = '0;
  end
  // token pulse; the answer stands only in the token cycle
  task automatic knock();
    token_o = 1'b1;
    #1;
    zlp_seen = zlp_i;
    nak_seen = nak_i;
    nrdy_seen = nrdy_i;
    @(posedge clock_i);
    #2;
    token_o = 1'b0;
  endtask
  // answer from the host after the last word
  task automatic serve(input logic ok);
    int n;
    n = (int'(len_i) + 3) / 4;
    knock();
    // fetch strobe held high gives one word per cycle
    word_o = (n > 0);
    for (int i = 0; i < n; i++) begin
      @(posedge clock_i);
      #2;
      if (i == 0) first_word = data_i;
      if (i == n - 1) word_o = 1'b0;
    end
    done_o = 1'b1;
    result_o = '{ack: ok, nack: !ok};
    @(posedge clock_i);
    #2;
    done_o = 1'b0;
    result_o = '0;
    rew_seen = rewind_i;
    ack_seen = notify_i;
  endtask
endmodule

// ---- verification/usb_bulk_in_frame_encapsulator_tb.sv ----
// self-checking bench for the bulk-in frame encapsulator
module usb_bulk_in_frame_encapsulator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  logic clock_i = 1'b0;
  logic reset_n_i, multi_frame_packing_i, empty_in_response_bit_i;
  logic [15:0] in_delay_register_i;
  logic burst_limit_enable_i;
  logic [7:0] burst_limit_i;
  logic [3:0] ss_max_burst_field_i;
  logic [1:0] speed_i;
  logic [13:0] rx_fifo_size_i;
  logic [31:0] rx_data_i, tx_data_o;
  logic rx_pop_o, rewind_o, ack_notify_o, token_i, tx_word_i, tx_done_i;
  bulk_in_pkg::in_result_t result_i;
  logic [10:0] pkt_len_o;
  logic [5:0] pkt_count_o;
  logic send_zlp_o, send_nak_o, send_nrdy_o, release_o, cmd_full_o;
  int err_total = 0, samples_checked = 0, cycles = 0, idx = 0, waited;
  logic [13:0] cur_len = '0;
  logic [10:0] exp_q[$];
  logic ok;
  always #25 clock_i = ~clock_i;
  usb_bulk_in_frame_encapsulator dut (
    .clock_i(clock_i), .reset_n_i(reset_n_i),
    .multi_frame_packing_i(multi_frame_packing_i),
    .empty_in_response_bit_i(empty_in_response_bit_i),
    .burst_limit_enable_i(burst_limit_enable_i),
    .burst_limit_i(burst_limit_i),
    .in_delay_register_i(in_delay_register_i),
    .ss_max_burst_field_i(ss_max_burst_field_i), .speed_i(speed_i),
    .rx_fifo_size_i(rx_fifo_size_i), .rx_data_i(rx_data_i),
    .rx_pop_o(rx_pop_o), .rewind_o(rewind_o), .ack_notify_o(ack_notify_o),
    .token_i(token_i), .tx_word_i(tx_word_i), .tx_done_i(tx_done_i),
    .result_i(result_i), .pkt_len_o(pkt_len_o), .pkt_count_o(pkt_count_o),
    .tx_data_o(tx_data_o), .send_zlp_o(send_zlp_o),
    .send_nak_o(send_nak_o), .send_nrdy_o(send_nrdy_o),
    .release_o(release_o), .cmd_full_o(cmd_full_o));
  usb_dev_model usb_device_controller (
    .clock_i(clock_i), .len_i(pkt_len_o), .data_i(tx_data_o),
    .zlp_i(send_zlp_o), .nak_i(send_nak_o), .nrdy_i(send_nrdy_o),
    .rewind_i(rewind_o), .notify_i(ack_notify_o), .token_o(token_i),
    .word_o(tx_word_i), .done_o(tx_done_i), .result_o(result_i));
  // ----------------------------------------
  // receive fifo source and helpers
  // ----------------------------------------
  // command a carries the length; words change as they are taken
  function automatic logic [31:0] word_at(int i, logic [13:0] len);
    if (i == 0) return {18'h00000, len};
    if (i < 3) return 32'h00000c00 + 32'(i);
    return {16'h0d0d, 16'(i)};
  endfunction
  assign rx_data_i = word_at(idx, cur_len);
  // size drops once the frame is being taken
  always @(posedge clock_i) begin
    if (rx_pop_o === 1'b1) begin
      idx <= idx + 1;
      rx_fifo_size_i <= 14'h0000;
    end
  end
  // hang guard well beyond the longest run of tests
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      $display("ERROR %0t run timed out", $time);
      give_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  // offer one whole frame; ok tells whether it was taken in time
  task automatic send_frame(input logic [13:0] len, input int guard);
    int n;
    n = 3 + (int'(len) + 3) / 4;
    cur_len = len;
    idx = 0;
    rx_fifo_size_i = len;
    for (int k = 0; k < guard && idx < n; k++) tick(1);
    ok = (idx == n);
  endtask
  // serve and acknowledge every expected packet in order
  task automatic drain();
    foreach (exp_q[i]) begin
      chk_val(32'(pkt_len_o), 32'(exp_q[i]));
      usb_device_controller.serve(1'b1);
      chk_bit(usb_device_controller.ack_seen, 1'b1);
      tick(1);
    end
    exp_q.delete();
    chk_val(32'(pkt_count_o), 32'h0);
  endtask
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    reset_n_i = 1'b0;
    multi_frame_packing_i = 1'b0;
    empty_in_response_bit_i = 1'b0;
    in_delay_register_i = 16'h0000;
    burst_limit_enable_i = 1'b0;
    burst_limit_i = 8'h04;
    ss_max_burst_field_i = 4'h3;
    speed_i = 2'h1;
    rx_fifo_size_i = 14'h0000;
    repeat (6) @(posedge clock_i);
    chk_val(32'(pkt_count_o), 32'h0);
    chk_bit(cmd_full_o, 1'b0);
    #2;
    reset_n_i = 1'b1;
    tick(3);
    $display("reset test done");
    // every speed with both empty responses
    for (int s = 0; s < 3; s++) begin
      for (int b = 0; b < 2; b++) begin
        speed_i = 2'(s);
        empty_in_response_bit_i = 1'(b);
        tick(1);
        usb_device_controller.knock();
        chk_bit(usb_device_controller.zlp_seen, b == 1);
        chk_bit(usb_device_controller.nak_seen, b == 0 && s != 2);
        chk_bit(usb_device_controller.nrdy_seen, b == 0 && s == 2);
      end
    end
    $display("empty token test done");
    // 12 command bytes plus 500 fill one hs packet exactly
    speed_i = 2'h1;
    send_frame(14'd500, 400);
    chk_bit(ok, 1'b1);
    tick(4);
    chk_val(32'(pkt_count_o), 32'h2);
    chk_val(32'(pkt_len_o), 32'h200);
    usb_device_controller.serve(1'b1);
    chk_val(usb_device_controller.first_word, 32'h000001f4);
    tick(1);
    exp_q = '{11'h000};
    drain();
    $display("exact multiple test done");
    // 152 bytes at fs split 64 64 24, first try refused
    speed_i = 2'h0;
    send_frame(14'd140, 200);
    tick(4);
    chk_val(32'(pkt_count_o), 32'h3);
    usb_device_controller.serve(1'b0);
    chk_bit(usb_device_controller.rew_seen, 1'b1);
    tick(1);
    chk_val(32'(pkt_count_o), 32'h3);
    exp_q = '{11'h040, 11'h040, 11'h018};
    drain();
    $display("split and retry test done");
    // 16 frames of 64 bytes plus zlp fill all 32 entries
    for (int f = 0; f < 16; f++) send_frame(14'd52, 200);
    tick(4);
    chk_bit(cmd_full_o, 1'b1);
    chk_val(32'(pkt_count_o), 32'h20);
    send_frame(14'd52, 50);
    chk_bit(ok, 1'b0);
    for (int p = 0; p < 34; p++) exp_q.push_back(p[0] ? 11'h000 : 11'h040);
    drain();
    $display("command full test done");
    // multi-frame short packet is held for the delay
    multi_frame_packing_i = 1'b1;
    in_delay_register_i = 16'd200;
    speed_i = 2'h1;
    send_frame(14'd100, 200);
    usb_device_controller.knock();
    chk_bit(usb_device_controller.nak_seen, 1'b1);
    waited = 0;
    // release only answers a token, so keep knocking until it shows
    while (release_o !== 1'b1 && waited < 400) begin
      usb_device_controller.knock();
      waited++;
    end
    chk_bit(waited > 150 && waited < 400, 1'b1);
    chk_val(32'(pkt_len_o), 32'h70);
    usb_device_controller.serve(1'b1);
    chk_bit(usb_device_controller.ack_seen, 1'b1);
    $display("delay test done");
    give_verdict();
  end
endmodule
